// ### design/ext_irq_unit.sv
// External interrupt controller with break protection and pending status
//
// How it works
// - Falling pin edge, or low level in level mode, sets the external flag.
// - The flag requests the processor only while the mask bit is clear.
// - Logic runs in wait standby; unmasked request raises the wake output.
// - Logic runs in stop standby; unmasked request raises the wake output.
// - With break-clear enable set, break accesses clear flags and they stay clear.
// - With break-clear enable clear, break accesses leave every status bit unchanged.
// - With break-clear enable clear, an armed two-step clear stays frozen in break and finishes after it.
// - Low pending register: flags 6..1 in bits 7..2, bits 1..0 read zero.
// - Mid pending register: flags 14..7 in bits 7..0.
// - High pending register: flags 22..15 in bits 7..0.
// - Pending registers read request state, ignore writes, reset to zero.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "irq_cfg.svh"
module ext_irq_unit
    import irq_pkg::*;
#(
    parameter int ADDR_W = 3
)(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [7:0]        rdata,
    // External interrupt pin, active low
    input  wire logic              irq_pin_n,
    // Processor state
    input  wire logic              break_active,
    input  wire logic              wait_mode,
    input  wire logic              stop_mode,
    // Request lines of the other sources
    input  wire logic [22:1]       src_req,
    // Requests to the processor
    output logic                   irq_req,
    output logic                   wake_req
);

    core_state_t   s_r;
    core_state_t   s_nxt;
    logic [22:1]   pend;
    logic          set_ev;
    logic          access_ok;
    logic          clr_write;
    logic          arm_read;

    pin_if pin ();

    pin_sync u_sync (
        .clock     (clock),
        .rst       (rst),
        .irq_pin_n (irq_pin_n),
        .pin       (pin)
    );

    pend_status u_pend (
        .clock   (clock),
        .rst     (rst),
        .src_req (src_req),
        .pend    (pend)
    );

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // Edge mode catches a pulse; level mode keeps the flag up while the pin is held
    assign set_ev = pin.fall | ((s_r.mode == TRIG_EDGE_LEVEL) & pin.level);

    // Accesses may only change status bits outside break, or in break with clearing enabled
    assign access_ok = ~break_active | s_r.bce;

    // First step: reading the control register while the flag is up
    assign arm_read  = rd & hit(addr, `OFF_STATUS_CTRL) & s_r.flag & access_ok;

    // Second step: writing one to the acknowledge bit
    assign clr_write = wr & hit(addr, `OFF_STATUS_CTRL) & wdata[`SC_ACK_BIT] & access_ok;

    always_comb begin
        s_nxt = s_r;

        // Control bits that are not status bits are writable at any time
        if (wr && hit(addr, `OFF_STATUS_CTRL)) begin
            s_nxt.mask = wdata[`SC_MASK_BIT];
            s_nxt.mode = trig_mode_t'(wdata[`SC_MODE_BIT]);
        end
        if (wr && hit(addr, `OFF_BREAK_CTRL)) begin
            s_nxt.bce = wdata[`BFC_BCE_BIT];
        end

        // Two-step clear; a set in the same cycle wins and forces a fresh read
        unique case (s_r.clr)
            CLR_IDLE: begin
                if (arm_read) begin
                    s_nxt.clr = CLR_ARMED;
                end
            end
            CLR_ARMED: begin
                if (clr_write) begin
                    s_nxt.clr  = CLR_IDLE;
                    s_nxt.flag = 1'b0;
                end
            end
        endcase

        if (set_ev) begin
            s_nxt.flag = 1'b1;
        end

        // Registered from next values so request tracks flag and mask exactly
        s_nxt.irq  = s_nxt.flag & ~s_nxt.mask;
        s_nxt.wake = s_nxt.flag & ~s_nxt.mask & (wait_mode | stop_mode);

        // Reads answer one cycle later; unmapped and idle cycles give zero
        s_nxt.rdata = `RDATA_RESET;
        if (rd) begin
            if (hit(addr, `OFF_STATUS_CTRL)) begin
                s_nxt.rdata[`SC_FLAG_BIT] = s_r.flag;
                s_nxt.rdata[`SC_MASK_BIT] = s_r.mask;
                s_nxt.rdata[`SC_MODE_BIT] = s_r.mode;
            end
            if (hit(addr, `OFF_BREAK_CTRL)) begin
                s_nxt.rdata[`BFC_BCE_BIT] = s_r.bce;
            end
            if (hit(addr, `OFF_PEND_LOW)) begin
                s_nxt.rdata = {pend[6:1], 2'b00};
            end
            if (hit(addr, `OFF_PEND_MID)) begin
                s_nxt.rdata = pend[14:7];
            end
            if (hit(addr, `OFF_PEND_HIGH)) begin
                s_nxt.rdata = pend[22:15];
            end
        end
        // Pending registers have no write path at all
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_r.flag  <= 1'b0;
            s_r.mask  <= `MASK_RESET;
            s_r.mode  <= TRIG_EDGE;
            s_r.bce   <= `BCE_RESET;
            s_r.clr   <= CLR_IDLE;
            s_r.irq   <= 1'b0;
            s_r.wake  <= 1'b0;
            s_r.rdata <= `RDATA_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata    = s_r.rdata;
    assign irq_req  = s_r.irq;
    assign wake_req = s_r.wake;

    a_flag_on_edge: assert property (@(posedge clock) disable iff (rst)
        pin.fall |=> s_r.flag)
        else $error("pin edge did not set flag");

    a_flag_on_level: assert property (@(posedge clock) disable iff (rst)
        (s_r.mode == TRIG_EDGE_LEVEL) && pin.level |=> s_r.flag)
        else $error("held pin did not keep flag set");

    a_edge_no_level: assert property (@(posedge clock) disable iff (rst)
        (s_r.mode == TRIG_EDGE) && !pin.fall && !s_r.flag |=> !s_r.flag)
        else $error("flag set without an edge");

    a_irq_gated: assert property (@(posedge clock) disable iff (rst)
        irq_req == (s_r.flag && !s_r.mask))
        else $error("request does not match flag and mask");

    a_mask_blocks: assert property (@(posedge clock) disable iff (rst)
        s_r.mask |-> !irq_req)
        else $error("masked flag reached processor");

    a_wake_wait: assert property (@(posedge clock) disable iff (rst)
        wait_mode && set_ev && !s_r.mask && !(wr && hit(addr, `OFF_STATUS_CTRL))
        |=> wake_req && irq_req)
        else $error("no wake from wait standby");

    a_wake_stop: assert property (@(posedge clock) disable iff (rst)
        stop_mode && set_ev && !s_r.mask && !(wr && hit(addr, `OFF_STATUS_CTRL))
        |=> wake_req && irq_req)
        else $error("no wake from stop standby");

    a_wake_idle: assert property (@(posedge clock) disable iff (rst)
        !$past(wait_mode) && !$past(stop_mode) |-> !wake_req)
        else $error("wake outside standby");

    a_break_clear: assert property (@(posedge clock) disable iff (rst)
        break_active && s_r.bce && s_r.clr == CLR_ARMED && !set_ev
        && wr && hit(addr, `OFF_STATUS_CTRL) && wdata[`SC_ACK_BIT]
        |=> !s_r.flag && s_r.clr == CLR_IDLE)
        else $error("enabled break clear failed");

    a_break_freeze: assert property (@(posedge clock) disable iff (rst)
        break_active && !s_r.bce && s_r.flag |=> s_r.flag)
        else $error("flag changed during protected break");

    a_break_arm_hold: assert property (@(posedge clock) disable iff (rst)
        break_active && !s_r.bce && !set_ev |=> $stable(s_r.clr))
        else $error("clear sequence moved during protected break");

    a_two_step: assert property (@(posedge clock) disable iff (rst)
        !break_active && s_r.clr == CLR_ARMED && !set_ev
        && wr && hit(addr, `OFF_STATUS_CTRL) && wdata[`SC_ACK_BIT]
        |=> !s_r.flag)
        else $error("second step did not clear flag");

    a_one_step_blocked: assert property (@(posedge clock) disable iff (rst)
        s_r.clr == CLR_IDLE && s_r.flag |=> s_r.flag)
        else $error("flag cleared without first step");

    a_pend_low: assert property (@(posedge clock) disable iff (rst)
        rd && hit(addr, `OFF_PEND_LOW) |=> rdata == {$past(pend[6:1]), 2'b00})
        else $error("low pending read wrong");

    a_pend_mid: assert property (@(posedge clock) disable iff (rst)
        rd && hit(addr, `OFF_PEND_MID) |=> rdata == $past(pend[14:7]))
        else $error("mid pending read wrong");

    a_pend_high: assert property (@(posedge clock) disable iff (rst)
        rd && hit(addr, `OFF_PEND_HIGH) |=> rdata == $past(pend[22:15]))
        else $error("high pending read wrong");

    a_read_one_cycle: assert property (@(posedge clock) disable iff (rst)
        !rd |=> rdata == 8'h00)
        else $error("read data outside answer cycle");

    a_pend_reset: assert property (@(posedge clock)
        rst |=> pend == 22'h000000)
        else $error("pending flags not cleared by reset");

    a_flag_reset: assert property (@(posedge clock)
        rst |=> !s_r.flag && !irq_req && !wake_req && rdata == 8'h00)
        else $error("request survived reset");

    a_mask_write: assert property (@(posedge clock) disable iff (rst)
        wr && hit(addr, `OFF_STATUS_CTRL) |=> s_r.mask == $past(wdata[`SC_MASK_BIT]))
        else $error("mask write lost");

    a_mask_hold: assert property (@(posedge clock) disable iff (rst)
        !(wr && hit(addr, `OFF_STATUS_CTRL)) |=> $stable(s_r.mask))
        else $error("mask changed without write");

    a_mode_write: assert property (@(posedge clock) disable iff (rst)
        wr && hit(addr, `OFF_STATUS_CTRL) |=> s_r.mode == $past(wdata[`SC_MODE_BIT]))
        else $error("trigger mode write lost");

    a_mode_hold: assert property (@(posedge clock) disable iff (rst)
        !(wr && hit(addr, `OFF_STATUS_CTRL)) |=> $stable(s_r.mode))
        else $error("trigger mode changed without write");

    a_bce_write: assert property (@(posedge clock) disable iff (rst)
        wr && hit(addr, `OFF_BREAK_CTRL) |=> s_r.bce == $past(wdata[`BFC_BCE_BIT]))
        else $error("break-clear enable write lost");

    a_bce_hold: assert property (@(posedge clock) disable iff (rst)
        !(wr && hit(addr, `OFF_BREAK_CTRL)) |=> $stable(s_r.bce))
        else $error("break-clear enable changed without write");

    a_wake_exact: assert property (@(posedge clock) disable iff (rst)
        wake_req == (s_r.flag && !s_r.mask && ($past(wait_mode) || $past(stop_mode))))
        else $error("wake does not match flag, mask and standby");

    a_arm_on_read: assert property (@(posedge clock) disable iff (rst)
        !break_active && rd && hit(addr, `OFF_STATUS_CTRL) && s_r.flag
        && s_r.clr == CLR_IDLE |=> s_r.clr == CLR_ARMED)
        else $error("read with flag up did not arm clear");

    a_break_no_arm: assert property (@(posedge clock) disable iff (rst)
        break_active && !s_r.bce && s_r.clr == CLR_IDLE |=> s_r.clr == CLR_IDLE)
        else $error("clear armed during protected break");

    a_break_bce_arm: assert property (@(posedge clock) disable iff (rst)
        break_active && s_r.bce && rd && hit(addr, `OFF_STATUS_CTRL) && s_r.flag
        && s_r.clr == CLR_IDLE |=> s_r.clr == CLR_ARMED)
        else $error("enabled break read did not arm clear");

    a_armed_flag: assert property (@(posedge clock) disable iff (rst)
        s_r.clr == CLR_ARMED |-> s_r.flag)
        else $error("clear armed with flag down");

    a_flag_rise_cause: assert property (@(posedge clock) disable iff (rst)
        $rose(s_r.flag) |-> $past(set_ev))
        else $error("flag rose without pin event");

    a_flag_fall_cause: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) && $fell(s_r.flag) |-> $past(clr_write && s_r.clr == CLR_ARMED))
        else $error("flag fell without second step");

    a_flag_readback: assert property (@(posedge clock) disable iff (rst)
        rd && hit(addr, `OFF_STATUS_CTRL) |=> rdata[`SC_FLAG_BIT] == $past(s_r.flag)
        && rdata[`SC_ACK_BIT] == 1'b0)
        else $error("flag read wrong");

    a_mask_readback: assert property (@(posedge clock) disable iff (rst)
        rd && hit(addr, `OFF_STATUS_CTRL) |=> rdata[`SC_MASK_BIT] == $past(s_r.mask))
        else $error("mask read wrong");

    a_bce_readback: assert property (@(posedge clock) disable iff (rst)
        rd && hit(addr, `OFF_BREAK_CTRL) |=> rdata[`BFC_BCE_BIT] == $past(s_r.bce))
        else $error("break-clear enable read wrong");

    a_pend_low_zero: assert property (@(posedge clock) disable iff (rst)
        rd && hit(addr, `OFF_PEND_LOW) |=> rdata[1:0] == 2'b00)
        else $error("low pending register bits 1..0 not zero");

    a_pend_track: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) |-> pend == $past(src_req))
        else $error("pending flags do not follow requests");

    a_pend_nowrite: assert property (@(posedge clock) disable iff (rst)
        wr |=> pend == $past(src_req))
        else $error("write disturbed pending flags");

    a_no_flag_idle: assert property (@(posedge clock) disable iff (rst)
        !s_r.flag |-> !irq_req && !wake_req)
        else $error("request without flag");

    a_wake_masked: assert property (@(posedge clock) disable iff (rst)
        s_r.mask |-> !wake_req)
        else $error("masked flag woke processor");

    a_stop_wake_hold: assert property (@(posedge clock) disable iff (rst)
        stop_mode && s_r.flag && !s_r.mask && !(wr && hit(addr, `OFF_STATUS_CTRL))
        |=> wake_req)
        else $error("pending flag did not wake from stop");

    a_wait_wake_hold: assert property (@(posedge clock) disable iff (rst)
        wait_mode && s_r.flag && !s_r.mask && !(wr && hit(addr, `OFF_STATUS_CTRL))
        |=> wake_req)
        else $error("pending flag did not wake from wait");

    a_level_set: assert property (@(posedge clock) disable iff (rst)
        (s_r.mode == TRIG_EDGE_LEVEL) && pin.level && !s_r.mask
        && !(wr && hit(addr, `OFF_STATUS_CTRL)) |=> irq_req)
        else $error("held pin gave no request");

    a_clear_drops: assert property (@(posedge clock) disable iff (rst)
        s_r.clr == CLR_ARMED && clr_write && !set_ev |=> !irq_req && !wake_req)
        else $error("request stayed after clear");

endmodule
`default_nettype wire

// ### design/pend_status.sv
// Registered copy of the 22 pending request lines
`timescale 1ns/1ps
`default_nettype none
`include "irq_cfg.svh"
module pend_status
    import irq_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Request lines of the sources
    input  wire logic [22:1] src_req,
    // Registered flags
    output logic      [22:1] pend
);
    pend_state_t s_r;
    pend_state_t s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.pend = src_req;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= `PEND_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pend = s_r.pend;

    a_pend_follow: assert property (@(posedge clock) disable iff (rst)
        !src_req[1] ##1 !src_req[1] |-> !pend[1]) else $error("flag held without request");
endmodule
`default_nettype wire

// ### design/pin_sync.sv
// Two-flop synchroniser and falling-edge detector for the interrupt pin
`timescale 1ns/1ps
`default_nettype none
`include "irq_cfg.svh"
module pin_sync
    import irq_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Pin, active low
    input  wire logic irq_pin_n,
    // Synchronised view
    pin_if.src        pin
);
    sync_state_t s_r;
    sync_state_t s_nxt;

    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = irq_pin_n;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
    end

    // Idle high so a reset never looks like an edge
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= {`PIN_IDLE, `PIN_IDLE, `PIN_IDLE};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pin.level = ~s_r.s2;
    assign pin.fall  = s_r.s3 & ~s_r.s2;

    a_fall_single: assert property (@(posedge clock) disable iff (rst)
        pin.fall |=> !pin.fall) else $error("edge pulse longer than one cycle");
endmodule
`default_nettype wire

// ### inc/irq_cfg.svh
// Offsets, field positions and reset values of the external interrupt block
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

`define OFF_STATUS_CTRL   3'h0
`define OFF_BREAK_CTRL    3'h1
`define OFF_PEND_LOW      3'h2
`define OFF_PEND_MID      3'h3
`define OFF_PEND_HIGH     3'h4

`define SC_MODE_BIT       0
`define SC_MASK_BIT       1
`define SC_ACK_BIT        2
`define SC_FLAG_BIT       3
`define BFC_BCE_BIT       7

`define MASK_RESET        1'b0
`define BCE_RESET         1'b0
`define PEND_RESET        22'h000000
`define RDATA_RESET       8'h00
`define PIN_IDLE          1'b1

`endif

// ### inc/irq_pkg.sv
// Types shared by the external interrupt block
package irq_pkg;

    typedef enum logic {
        TRIG_EDGE,
        TRIG_EDGE_LEVEL
    } trig_mode_t;

    typedef enum logic {
        CLR_IDLE,
        CLR_ARMED
    } clr_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_state_t;

    typedef struct packed {
        logic [22:1] pend;
    } pend_state_t;

    typedef struct packed {
        logic        flag;
        logic        mask;
        trig_mode_t  mode;
        logic        bce;
        clr_state_t  clr;
        logic        irq;
        logic        wake;
        logic [7:0]  rdata;
    } core_state_t;

endpackage

// ### inc/pin_if.sv
// Synchronised interrupt pin as seen by the controller
`timescale 1ns/1ps
`default_nettype none
interface pin_if;
    logic level;
    logic fall;
    modport src (output level, output fall);
    modport dst (input level, input fall);
endinterface
`default_nettype wire

// ### sim/irq_source.sv
// Behavioural external interrupt source driving the active-low pin
`timescale 1ns/1ps
`default_nettype none
module irq_source (
    // Clock
    input  wire logic clock,
    // Commands from the bench
    input  wire logic fire,
    input  wire logic hold,
    // Pin, active low
    output logic      pin_n
);
    logic [1:0] cnt_r = 2'h0;
    // Low for three cycles, so the two-flop sync cannot miss it
    always @(posedge clock) begin
        if (fire) begin
            cnt_r <= 2'h3;
        end else if (cnt_r != 2'h0) begin
            cnt_r <= cnt_r - 2'h1;
        end
    end
    // Released pin returns high through the pull-up
    assign pin_n = (cnt_r == 2'h0) && !hold;
endmodule
`default_nettype wire

// ### sim/tb_ext_interrupt_and_pending_status.sv
// Self-checking bench for the external interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_ext_interrupt_and_pending_status;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic        irq_pin_n;
    logic        break_active = 1'b0;
    logic        wait_mode = 1'b0;
    logic        stop_mode = 1'b0;
    logic [22:1] src_req = 22'h000000;
    logic [22:1] p;
    logic        irq_req;
    logic        wake_req;
    logic        fire = 1'b0;
    logic        hold = 1'b0;
    logic [7:0]  d;
    int          fails = 0;
    int          n_compared = 0;

    always #20 clock = ~clock;

    ext_irq_unit #(.ADDR_W(3)) DUT (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq_pin_n(irq_pin_n),
        .break_active(break_active), .wait_mode(wait_mode), .stop_mode(stop_mode),
        .src_req(src_req), .irq_req(irq_req), .wake_req(wake_req));
    irq_source src (.clock(clock), .fire(fire), .hold(hold), .pin_n(irq_pin_n));

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clock);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Six cycles covers sync plus edge detect with margin
    task automatic pulse;
        @(posedge clock);
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
        settle(6);
    endtask

    task automatic clr_flag(input logic [7:0] ctl);
        rd_reg(3'h0);
        wr_reg(3'h0, ctl | 8'h04);
        settle(1);
    endtask

    task automatic t_reset;
        for (int a = 0; a < 6; a++) begin
            rd_reg(a[2:0]);
            `CHK("reset read", 8'h00, d)
        end
        $display("test reset done");
    endtask

    task automatic t_pend;
        for (int i = 0; i < 2; i++) begin
            p = (i == 0) ? 22'h35A5C3 : 22'h0A5A3C;
            src_req <= p;
            for (int a = 2; a < 5; a++) wr_reg(a[2:0], 8'hFF);
            settle(2);
            rd_reg(3'h2);
            `CHK("pend low", {p[6:1], 2'b00}, d)
            rd_reg(3'h3);
            `CHK("pend mid", p[14:7], d)
            rd_reg(3'h4);
            `CHK("pend high", p[22:15], d)
        end
        src_req <= 22'h000000;
        settle(2);
        for (int a = 2; a < 5; a++) begin
            rd_reg(a[2:0]);
            `CHK("pend withdrawn", 8'h00, d)
        end
        $display("test pending done");
    endtask

    task automatic t_edge_mask;
        wr_reg(3'h0, 8'h02);
        pulse();
        `CHK("masked irq", 1'b0, irq_req)
        rd_reg(3'h0);
        `CHK("flag set", 1'b1, d[3])
        wr_reg(3'h0, 8'h00);
        settle(1);
        `CHK("unmasked irq", 1'b1, irq_req)
        wr_reg(3'h0, 8'h04);
        settle(1);
        `CHK("irq after clear", 1'b0, irq_req)
        pulse();
        wr_reg(3'h0, 8'h04);
        settle(1);
        `CHK("ack without read", 1'b1, irq_req)
        clr_flag(8'h00);
        $display("test edge and mask done");
    endtask

    task automatic t_standby;
        wait_mode <= 1'b1;
        pulse();
        `CHK("wake from wait", 1'b1, wake_req)
        clr_flag(8'h00);
        wait_mode <= 1'b0;
        stop_mode <= 1'b1;
        wr_reg(3'h0, 8'h02);
        pulse();
        `CHK("masked wake", 1'b0, wake_req)
        wr_reg(3'h0, 8'h00);
        settle(1);
        `CHK("wake from stop", 1'b1, wake_req)
        clr_flag(8'h00);
        pulse();
        `CHK("stop edge wakes", 1'b1, wake_req)
        clr_flag(8'h00);
        `CHK("stop wake cleared", 1'b0, wake_req)
        stop_mode <= 1'b0;
        $display("test standby done");
    endtask

    // Break state must not disturb a flag unless break-clear is on
    task automatic t_break;
        pulse();
        break_active <= 1'b1;
        clr_flag(8'h00);
        `CHK("protected in break", 1'b1, irq_req)
        break_active <= 1'b0;
        wr_reg(3'h0, 8'h04);
        settle(1);
        `CHK("break read no arm", 1'b1, irq_req)
        rd_reg(3'h0);
        break_active <= 1'b1;
        wr_reg(3'h0, 8'h04);
        settle(1);
        `CHK("armed frozen", 1'b1, irq_req)
        break_active <= 1'b0;
        wr_reg(3'h0, 8'h04);
        settle(1);
        `CHK("second step clears", 1'b0, irq_req)
        wr_reg(3'h1, 8'h80);
        pulse();
        break_active <= 1'b1;
        clr_flag(8'h00);
        `CHK("cleared in break", 1'b0, irq_req)
        break_active <= 1'b0;
        rd_reg(3'h0);
        `CHK("stays cleared", 8'h00, d)
        wr_reg(3'h1, 8'h00);
        $display("test break done");
    endtask

    task automatic t_level;
        wr_reg(3'h0, 8'h01);
        hold <= 1'b1;
        settle(6);
        `CHK("level sets", 1'b1, irq_req)
        clr_flag(8'h01);
        `CHK("level re-sets", 1'b1, irq_req)
        hold <= 1'b0;
        settle(4);
        clr_flag(8'h00);
        `CHK("level released", 1'b0, irq_req)
        $display("test level done");
    endtask

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_pend();
        t_edge_mask();
        t_standby();
        t_break();
        t_level();
        give_verdict();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        give_verdict();
    end
endmodule
`default_nettype wire
